// ===== src/rss_top.sv
// Event selection and qualification for alias table and segment rename stalls
// How it works
// [R01] Umask 02H of D2H counts cycles lengthened by a partly written register.
// [R02] Umask 04H of D2H counts flag stall cycles, partial flag stall included.
// [R03] Partial flag stall: subset flag write, then consumer needs unwritten flags.
// [R04] Umask 08H of D2H adds two per status word write.
// [R05] Umask 0FH of D2H counts cycles of any alias table stall cause.
// [R06] D4H umasks 01H..08H count rename stalls of one segment register.
// [R07] D4H umask 0FH counts rename stalls of any of four segments.
// [R08] Second update to an unretired renamed segment stalls front end until retire.
// [R09] Umask 01H of D2H counts every read port stall cycle, retries too.
// [R10] Selection checked each cycle; one increment at most; unlisted umasks count nothing.
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "rss_params.svh"
module rss_top (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [31:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [31:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   reorder_read_port_stall,
  input  wire logic                   partial_register_stall_cond,
  input  wire logic                   flag_stall_other,
  input  wire logic                   flag_wr_valid,
  input  wire logic [`RSS_FLAG_W-1:0] flag_wr_mask,
  input  wire logic                   flag_use_valid,
  input  wire logic [`RSS_FLAG_W-1:0] flag_use_mask,
  input  wire logic                   fp_status_word_write,
  input  wire logic [`RSS_SEG_N-1:0]  seg_update,
  input  wire logic [`RSS_SEG_N-1:0]  seg_retire,
  output logic [`RSS_SEG_N-1:0]       seg_front_end_stall,
  output logic [1:0]                  count_inc
);
  logic [31:0]            ctrl_ff, nxt_ctrl;
  logic [31:0]            stat_ff, nxt_stat;
  logic                   aw_held_ff, nxt_aw_held, w_held_ff, nxt_w_held;
  logic [31:0]            aw_addr_ff, nxt_aw_addr, w_data_ff, nxt_w_data;
  logic [3:0]             w_strb_ff, nxt_w_strb;
  logic                   bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [1:0]             bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0]            rdata_ff, nxt_rdata;
  logic                   arready_ff, nxt_arready;
  // Ready flags kept as their own flops so the outputs leave straight from registers
  logic                   awready_ff, wready_ff;
  logic                   do_write;
  logic [`RSS_FLAG_W-1:0] last_mask_ff, nxt_last_mask;
  logic                   last_partial_ff, nxt_last_partial;
  logic                   partial_flag_stall;
  logic                   flag_stall_cycles;
  logic [`RSS_SEG_N-1:0]  seg_start;
  logic [1:0]             inc_ff, nxt_inc;
  logic [7:0]             evt, umask;
  logic                   enabled;
  rss_pkg::rss_sel_t      sel;
  logic [1:0]             seg_idx;

  genvar gi;
  generate
    for (gi = 0; gi < `RSS_SEG_N; gi++)
    begin : g_seg
      rss_seg_tracker u_trk (
        .clk            (clk),
        .rst_n          (rst_n),
        .seg_update     (seg_update[gi]),
        .seg_retire     (seg_retire[gi]),
        .stall_ff       (seg_front_end_stall[gi]),
        .stall_start_ff (seg_start[gi])
      );
    end
  endgenerate

  // Register bus: address and data may arrive in either order
  always_comb
  begin
    do_write    = aw_held_ff & w_held_ff & ~bvalid_ff;
    nxt_aw_held = aw_held_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_held  = w_held_ff;
    nxt_w_data  = w_data_ff;
    nxt_w_strb  = w_strb_ff;
    nxt_bvalid  = bvalid_ff & ~s_axi_bready;
    nxt_bresp   = bresp_ff;
    nxt_ctrl    = ctrl_ff;
    if (s_axi_awvalid && !aw_held_ff)
    begin
      nxt_aw_held = 1'b1;
      nxt_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_ff)
    begin
      nxt_w_held = 1'b1;
      nxt_w_data = s_axi_wdata;
      nxt_w_strb = s_axi_wstrb;
    end
    if (do_write)
    begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = `RSS_RESP_OKAY;
      if ({aw_addr_ff[31:2], 2'b00} == `RSS_CTRL_OFS)
      begin
        for (int b = 0; b < 4; b++)
          if (w_strb_ff[b])
            nxt_ctrl[b*8 +: 8] = w_data_ff[b*8 +: 8];
        nxt_ctrl = nxt_ctrl & `RSS_CTRL_MASK;
      end
      else if ({aw_addr_ff[31:2], 2'b00} != `RSS_STAT_OFS)
        nxt_bresp = `RSS_RESP_SLVERR;
    end
  end

  always_comb
  begin
    nxt_rvalid  = rvalid_ff & ~s_axi_rready;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    nxt_arready = ~nxt_rvalid;
    if (s_axi_arvalid && arready_ff)
    begin
      nxt_rvalid  = 1'b1;
      nxt_arready = 1'b0;
      nxt_rresp   = `RSS_RESP_OKAY;
      if ({s_axi_araddr[31:2], 2'b00} == `RSS_CTRL_OFS)
        nxt_rdata = ctrl_ff;
      else if ({s_axi_araddr[31:2], 2'b00} == `RSS_STAT_OFS)
        nxt_rdata = stat_ff;
      else
      begin
        nxt_rdata = 32'h0000_0000;
        nxt_rresp = `RSS_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_ff    <= `RSS_CTRL_RST;
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 32'h0000_0000;
      w_held_ff  <= 1'b0;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'h0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= 2'h0;
      arready_ff <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
    end
    else
    begin
      ctrl_ff    <= nxt_ctrl;
      aw_held_ff <= nxt_aw_held;
      aw_addr_ff <= nxt_aw_addr;
      w_held_ff  <= nxt_w_held;
      w_data_ff  <= nxt_w_data;
      w_strb_ff  <= nxt_w_strb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
      arready_ff <= nxt_arready;
      awready_ff <= ~nxt_aw_held;
      wready_ff  <= ~nxt_w_held;
    end
  end

  // Only the next flag consumer is compared against the last flag writer
  always_comb
  begin
    partial_flag_stall = last_partial_ff & flag_use_valid
                         & (|(flag_use_mask & ~last_mask_ff)); // R03
    flag_stall_cycles  = flag_stall_other | partial_flag_stall; // R02
    nxt_last_mask      = last_mask_ff;
    nxt_last_partial   = last_partial_ff & ~flag_use_valid;
    if (flag_wr_valid)
    begin
      nxt_last_mask    = flag_wr_mask;
      nxt_last_partial = (flag_wr_mask != `RSS_FLAG_ALL); // R03
    end
  end

  // Event decode, re-evaluated every cycle from the live control word
  always_comb
  begin
    evt     = ctrl_ff[`RSS_CTRL_EVT_LSB +: 8];
    umask   = ctrl_ff[`RSS_CTRL_UM_LSB +: 8];
    enabled = ctrl_ff[`RSS_CTRL_EN_BIT];
    sel     = rss_pkg::RSS_SEL_NONE;
    seg_idx = 2'h0;
    if (evt == `RSS_EVT_ALIAS)
    begin
      unique case (umask)
        `RSS_UM_ROB:  sel = rss_pkg::RSS_SEL_ROB;
        `RSS_UM_PART: sel = rss_pkg::RSS_SEL_PART;
        `RSS_UM_FLAG: sel = rss_pkg::RSS_SEL_FLAG;
        `RSS_UM_FP_STATUS_WORD: sel = rss_pkg::RSS_SEL_FP_STATUS_WORD;
        `RSS_UM_ANY:  sel = rss_pkg::RSS_SEL_RANY;
        default:      sel = rss_pkg::RSS_SEL_NONE; // R10
      endcase
    end
    else if (evt == `RSS_EVT_SEG)
    begin
      unique case (umask)
        `RSS_UM_ROB:  begin sel = rss_pkg::RSS_SEL_SEG; seg_idx = 2'h0; end // R06
        `RSS_UM_PART: begin sel = rss_pkg::RSS_SEL_SEG; seg_idx = 2'h1; end
        `RSS_UM_FLAG: begin sel = rss_pkg::RSS_SEL_SEG; seg_idx = 2'h2; end
        `RSS_UM_FP_STATUS_WORD: begin sel = rss_pkg::RSS_SEL_SEG; seg_idx = 2'h3; end
        `RSS_UM_ANY:  sel = rss_pkg::RSS_SEL_SANY;
        default:      sel = rss_pkg::RSS_SEL_NONE; // R10
      endcase
    end
    nxt_inc = 2'h0;
    unique case (sel)
      rss_pkg::RSS_SEL_ROB:  if (reorder_read_port_stall) nxt_inc = `RSS_INC_ONE; // R09
      rss_pkg::RSS_SEL_PART: if (partial_register_stall_cond) nxt_inc = `RSS_INC_ONE; // R01
      rss_pkg::RSS_SEL_FLAG: if (flag_stall_cycles) nxt_inc = `RSS_INC_ONE; // R02
      rss_pkg::RSS_SEL_FP_STATUS_WORD: if (fp_status_word_write) nxt_inc = `RSS_INC_FP_STATUS_WORD; // R04
      rss_pkg::RSS_SEL_RANY:
        if (reorder_read_port_stall | partial_register_stall_cond
            | flag_stall_cycles | fp_status_word_write)
          nxt_inc = `RSS_INC_ONE; // R05
      rss_pkg::RSS_SEL_SEG:  if (seg_start[seg_idx]) nxt_inc = `RSS_INC_ONE; // R06
      rss_pkg::RSS_SEL_SANY: if (|seg_start) nxt_inc = `RSS_INC_ONE; // R07
      rss_pkg::RSS_SEL_NONE: nxt_inc = 2'h0; // R10
    endcase
    if (!enabled)
      nxt_inc = 2'h0;
    nxt_stat = {20'h0_0000, seg_front_end_stall, 3'h0, fp_status_word_write,
                flag_stall_cycles, partial_flag_stall, partial_register_stall_cond,
                reorder_read_port_stall};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_mask_ff    <= `RSS_FLAG_ALL;
      last_partial_ff <= 1'b0;
      inc_ff          <= 2'h0;
      stat_ff         <= 32'h0000_0000;
    end
    else
    begin
      last_mask_ff    <= nxt_last_mask;
      last_partial_ff <= nxt_last_partial;
      inc_ff          <= nxt_inc;
      stat_ff         <= nxt_stat;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign count_inc     = inc_ff;

  a_part_reg : assert property (@(posedge clk) disable iff (!rst_n) // R01
    (enabled && sel == rss_pkg::RSS_SEL_PART && partial_register_stall_cond)
    |=> count_inc == 2'h1) else $error("partial register cycle not counted");
  a_flag_cycle : assert property (@(posedge clk) disable iff (!rst_n) // R02
    (enabled && sel == rss_pkg::RSS_SEL_FLAG && flag_use_valid && last_partial_ff
     && (|(flag_use_mask & ~last_mask_ff))) |=> count_inc == 2'h1)
    else $error("partial flag stall not counted as flag stall");
  a_flag_full : assert property (@(posedge clk) disable iff (!rst_n) // R03
    (flag_wr_valid && flag_wr_mask == `RSS_FLAG_ALL) |=> !partial_flag_stall)
    else $error("partial flag stall after full flag write");
  a_fp_status_word_double : assert property (@(posedge clk) disable iff (!rst_n) // R04
    (enabled && sel == rss_pkg::RSS_SEL_FP_STATUS_WORD && fp_status_word_write)
    |=> count_inc == 2'h2) else $error("status word write did not add two");
  a_alias_any : assert property (@(posedge clk) disable iff (!rst_n) // R05
    (enabled && sel == rss_pkg::RSS_SEL_RANY && (reorder_read_port_stall
     || fp_status_word_write)) |=> count_inc == 2'h1)
    else $error("any alias stall not counted once");
  a_seg_one : assert property (@(posedge clk) disable iff (!rst_n) // R06
    (enabled && sel == rss_pkg::RSS_SEL_SEG && seg_start[seg_idx])
    |=> count_inc == 2'h1) else $error("segment stall not counted");
  a_seg_any : assert property (@(posedge clk) disable iff (!rst_n) // R07
    (enabled && sel == rss_pkg::RSS_SEL_SANY) |=> count_inc == {1'b0, $past(|seg_start)})
    else $error("any segment stall miscounted");
  a_rob_retry : assert property (@(posedge clk) disable iff (!rst_n) // R09
    (enabled && sel == rss_pkg::RSS_SEL_ROB && reorder_read_port_stall)[*2]
    |=> count_inc == 2'h1 && $past(count_inc) == 2'h1)
    else $error("read port retry cycle not counted again");
  a_unlisted : assert property (@(posedge clk) disable iff (!rst_n) // R10
    (sel == rss_pkg::RSS_SEL_NONE || !enabled) |=> count_inc == 2'h0)
    else $error("count with no event selected");
endmodule // rss_top
`default_nettype wire

// ===== src/rss_params.svh
// Constants for the rename stall event selector
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH
`define RSS_CTRL_OFS      32'h0000_0000
`define RSS_STAT_OFS      32'h0000_0004
`define RSS_CTRL_RST      32'h0000_0000
`define RSS_CTRL_EVT_LSB  0
`define RSS_CTRL_UM_LSB   8
`define RSS_CTRL_EN_BIT   16
`define RSS_CTRL_MASK     32'h0001_ffff
`define RSS_EVT_ALIAS     8'hd2
`define RSS_EVT_SEG       8'hd4
`define RSS_UM_ROB        8'h01
`define RSS_UM_PART       8'h02
`define RSS_UM_FLAG       8'h04
`define RSS_UM_FP_STATUS_WORD       8'h08
`define RSS_UM_ANY        8'h0f
`define RSS_SEG_N         4
`define RSS_FLAG_W        6
`define RSS_FLAG_ALL      6'h3f
`define RSS_INC_ONE       2'h1
`define RSS_INC_FP_STATUS_WORD      2'h2
`define RSS_RESP_OKAY     2'h0
`define RSS_RESP_SLVERR   2'h2
`endif

// ===== src/rss_pkg.sv
// Types for the rename stall event selector
package rss_pkg;
  typedef enum logic [2:0] {
    RSS_SEL_NONE,
    RSS_SEL_ROB,
    RSS_SEL_PART,
    RSS_SEL_FLAG,
    RSS_SEL_FP_STATUS_WORD,
    RSS_SEL_RANY,
    RSS_SEL_SEG,
    RSS_SEL_SANY
  } rss_sel_t;
endpackage

// ===== src/rss_seg_tracker.sv
// Rename tracking and front end stall for one segment register
`timescale 1ns/1ns
`default_nettype none
module rss_seg_tracker (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic seg_update,
  input  wire logic seg_retire,
  output logic      stall_ff,
  output logic      stall_start_ff
);
  logic pending_ff;
  logic nxt_pending;
  logic nxt_stall;
  logic nxt_stall_start;

  // Front end holds seg_update high while stalled; retire releases it
  always_comb
  begin
    nxt_stall       = (stall_ff | (seg_update & pending_ff)) & ~seg_retire; // R08
    nxt_stall_start = seg_update & pending_ff & ~seg_retire & ~stall_ff;
    if (seg_retire)
      nxt_pending = stall_ff | seg_update;
    else
      nxt_pending = pending_ff | seg_update;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pending_ff     <= 1'b0;
      stall_ff       <= 1'b0;
      stall_start_ff <= 1'b0;
    end
    else
    begin
      pending_ff     <= nxt_pending;
      stall_ff       <= nxt_stall;
      stall_start_ff <= nxt_stall_start;
    end
  end

  a_stall_holds : assert property (@(posedge clk) disable iff (!rst_n)
    (stall_ff && !seg_retire) |=> stall_ff) // R08
    else $error("segment stall dropped before retire");
endmodule // rss_seg_tracker
`default_nettype wire

// ===== dv/rss_top_test.sv
// Self-checking bench for the rename stall event selector
`timescale 1ns/1ns
`default_nettype none
`include "rss_params.svh"
module rss_top_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] s_axi_awaddr = '0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [31:0] s_axi_araddr = '0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic [3:0]  ev_s = 4'h0;
  logic        fwv = 1'b0;
  logic        fuv = 1'b0;
  logic [5:0]  fwm = 6'h3f;
  logic [5:0]  fum = 6'h00;
  logic [3:0]  su = 4'h0;
  logic [3:0]  sr = 4'h0;
  logic [3:0]  stall;
  logic [1:0]  count_inc;
  int          error_cnt = 0;
  int          num_checks = 0;
  // Alias table cases: umask, stimulus {rob, partial, flag, fp_status_word}, expected increment
  localparam logic [13:0] TBL [14] = '{
    {8'h01, 4'h8, 2'h1}, {8'h01, 4'h4, 2'h0}, {8'h02, 4'h4, 2'h1}, {8'h02, 4'h8, 2'h0},
    {8'h04, 4'h2, 2'h1}, {8'h04, 4'h1, 2'h0}, {8'h08, 4'h1, 2'h2}, {8'h08, 4'h4, 2'h0},
    {8'h0f, 4'h8, 2'h1}, {8'h0f, 4'h4, 2'h1}, {8'h0f, 4'h2, 2'h1}, {8'h0f, 4'h1, 2'h1},
    {8'h0f, 4'hf, 2'h1}, {8'h03, 4'hf, 2'h0}};

  always #50 clk = ~clk;

  rss_top dut_u (
    .clk                         (clk),
    .rst_n                       (rst_n),
    .s_axi_awaddr                (s_axi_awaddr),
    .s_axi_awvalid               (s_axi_awvalid),
    .s_axi_awready               (s_axi_awready),
    .s_axi_wdata                 (s_axi_wdata),
    .s_axi_wstrb                 (s_axi_wstrb),
    .s_axi_wvalid                (s_axi_wvalid),
    .s_axi_wready                (s_axi_wready),
    .s_axi_bresp                 (s_axi_bresp),
    .s_axi_bvalid                (s_axi_bvalid),
    .s_axi_bready                (s_axi_bready),
    .s_axi_araddr                (s_axi_araddr),
    .s_axi_arvalid               (s_axi_arvalid),
    .s_axi_arready               (s_axi_arready),
    .s_axi_rdata                 (s_axi_rdata),
    .s_axi_rresp                 (s_axi_rresp),
    .s_axi_rvalid                (s_axi_rvalid),
    .s_axi_rready                (s_axi_rready),
    .reorder_read_port_stall     (ev_s[3]),
    .partial_register_stall_cond (ev_s[2]),
    .flag_stall_other            (ev_s[1]),
    .flag_wr_valid               (fwv),
    .flag_wr_mask                (fwm),
    .flag_use_valid              (fuv),
    .flag_use_mask               (fum),
    .fp_status_word_write        (ev_s[0]),
    .seg_update                  (su),
    .seg_retire                  (sr),
    .seg_front_end_stall         (stall),
    .count_inc                   (count_inc)
  );

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] xr);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, xr}, "bresp");
  endtask

  task axi_rd(input logic [31:0] a, input logic [31:0] x, input logic [1:0] xr);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, x, "rdata");
    chk({30'h0, s_axi_rresp}, {30'h0, xr}, "rresp");
  endtask

  task cfg(input logic [7:0] e, input logic [7:0] u, input logic en);
    axi_wr(`RSS_CTRL_OFS, {15'h0, en, u, e}, `RSS_RESP_OKAY);
  endtask

  // Holds a stall cause for n cycles, then expects the increment to drop
  task ev(input logic [3:0] s, input int n, input logic [1:0] x);
    @(posedge clk);
    ev_s <= s;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      if (i == n - 1) ev_s <= 4'h0;
      #1 chk({30'h0, count_inc}, {30'h0, x}, "count_inc");
    end
    @(posedge clk);
    #1 chk({30'h0, count_inc}, 32'h0, "count_inc idle");
  endtask

  task flg(input logic [5:0] w, input logic [5:0] u, input logic [1:0] x);
    @(posedge clk);
    fwv <= 1'b1;
    fwm <= w;
    @(posedge clk);
    fwv <= 1'b0;
    fuv <= 1'b1;
    fum <= u;
    @(posedge clk);
    fuv <= 1'b0;
    #1 chk({30'h0, count_inc}, {30'h0, x}, "flag count_inc");
  endtask

  // Rename, blocked second update, retire, then retire the held rename
  task seg(input int i, input logic [1:0] x);
    @(posedge clk);
    su[i] <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    #1 chk({28'h0, stall}, 32'h1 << i, "stall on");
    @(posedge clk);
    #1 chk({30'h0, count_inc}, {30'h0, x}, "seg count_inc");
    @(posedge clk);
    sr[i] <= 1'b1;
    #1 chk({28'h0, stall}, 32'h1 << i, "stall held");
    chk({30'h0, count_inc}, 32'h0, "one per stall");
    @(posedge clk);
    sr[i] <= 1'b0;
    su[i] <= 1'b0;
    #1 chk({28'h0, stall}, 32'h0, "stall off");
    @(posedge clk);
    sr[i] <= 1'b1;
    @(posedge clk);
    sr[i] <= 1'b0;
  endtask

  task final_report();
    if (error_cnt == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #4000000;
    error_cnt++;
    final_report();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    axi_rd(`RSS_CTRL_OFS, `RSS_CTRL_RST, `RSS_RESP_OKAY);
    axi_wr(32'h8, 32'h1234_5678, `RSS_RESP_SLVERR);
    axi_rd(32'h8, 32'h0, `RSS_RESP_SLVERR);
    axi_wr(`RSS_CTRL_OFS, 32'hffff_ffff, `RSS_RESP_OKAY);
    axi_rd(`RSS_CTRL_OFS, `RSS_CTRL_MASK, `RSS_RESP_OKAY);
    axi_wr(`RSS_STAT_OFS, 32'hffff_ffff, `RSS_RESP_OKAY);
    cfg(`RSS_EVT_ALIAS, `RSS_UM_FP_STATUS_WORD, 1'b0);
    ev(4'hf, 1, 2'h0);
    cfg(8'hd3, `RSS_UM_FP_STATUS_WORD, 1'b1);
    ev(4'hf, 1, 2'h0);
    for (int k = 0; k < 14; k++)
    begin
      cfg(`RSS_EVT_ALIAS, TBL[k][13:6], 1'b1);
      ev(TBL[k][5:2], 1, TBL[k][1:0]);
    end
    cfg(`RSS_EVT_ALIAS, `RSS_UM_ROB, 1'b1);
    ev(4'h8, 3, 2'h1);
    cfg(`RSS_EVT_ALIAS, `RSS_UM_FP_STATUS_WORD, 1'b1);
    ev(4'h1, 2, 2'h2);
    cfg(`RSS_EVT_ALIAS, `RSS_UM_FLAG, 1'b1);
    flg(6'h0f, 6'h30, 2'h1);
    flg(6'h0f, 6'h03, 2'h0);
    flg(6'h3f, 6'h30, 2'h0);
    cfg(`RSS_EVT_ALIAS, `RSS_UM_ANY, 1'b1);
    flg(6'h0f, 6'h30, 2'h1);
    cfg(`RSS_EVT_ALIAS, `RSS_UM_PART, 1'b1);
    flg(6'h0f, 6'h30, 2'h0);
    for (int i = 0; i < 4; i++)
    begin
      cfg(`RSS_EVT_SEG, 8'h01 << i, 1'b1);
      seg(i, 2'h1);
      cfg(`RSS_EVT_SEG, `RSS_UM_ANY, 1'b1);
      seg(i, 2'h1);
      cfg(`RSS_EVT_SEG, 8'h01 << ((i + 1) % 4), 1'b1);
      seg(i, 2'h0);
    end
    final_report();
  end
endmodule // rss_top_test
`default_nettype wire
